// ===== rtl/asf_pkg.sv
package asf_pkg;
  // ****************************************
  // register map
  // ****************************************
  localparam logic [7:0] ADDR_X_LO = 8'h32;
  localparam logic [7:0] ADDR_Z_HI = 8'h37;
  localparam logic [7:0] ADDR_CTRL = 8'h38;
  localparam logic [7:0] ADDR_BUFFER_STATUS = 8'h39;
  localparam logic [7:0] ADDR_SOURCE = 8'h30;
  // ****************************************
  // field layout
  // ****************************************
  localparam int MODE_HI = 7;
  localparam int MODE_LO = 6;
  localparam int TRIG_SEL_BIT = 5;
  localparam int SAMPLES_HI = 4;
  localparam int TRIG_FLAG_BIT = 7;
  localparam int SRC_READY_BIT = 7;
  localparam int SRC_WATERMARK_BIT = 1;
  localparam int SRC_OVERRUN_BIT = 0;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam int DEPTH = 32;
  localparam int SAMPLE_W = 48;
  // ****************************************
  // buffer modes and trigger states
  // ****************************************
  typedef enum logic [1:0] {
    ASF_BYPASS = 2'h0,
    ASF_FILL = 2'h1,
    ASF_STREAM = 2'h2,
    ASF_TRIGGER = 2'h3
  } asf_mode_t;
  typedef enum logic [2:0] {
    ASF_ST_IDLE = 3'h1,
    ASF_ST_ARMED = 3'h2,
    ASF_ST_FIRED = 3'h4
  } asf_trig_state_t;
endpackage

// ===== rtl/asf_sample_fifo.sv
// Overview of operation
// - two-bit mode field picks bypass, fill-and-stop, stream or trigger behaviour
// - fill-and-stop: accept until 33 held (32 stored plus output stage), then drop until not full
// - stream: keep newest 33 (32 stored plus output stage), overwriting oldest when full
// - trigger: keep pre-trigger samples, fill until full, then accept only when not full
// - trigger source is first event pin when select is 0, else second pin
// - fill and stream: sample count sets watermark level
// - trigger: sample count is number of samples kept in the store before trigger, plus one more in the output stage
// - bypass: sample count has no effect except that writing zero sets watermark
// - writing sample count zero sets watermark flag at once
// - top bit of buffer status shows trigger occurred
// - buffer status holds current entry count, readable any time
// - axis registers present samples; a read of them with burst_end high pops one level
// - 32 stored entries plus one output stage give 33 readable
// - watermark and overrun flags stick and clear via axis reads; ready follows whether a sample is readable
// - axis data twos complement, low byte at lower address
module asf_sample_fifo
  import asf_pkg::*;
#(
  parameter int DEPTH_P = DEPTH
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // sampling path
  input wire logic sample_valid,
  output logic sample_ready,
  input wire logic [SAMPLE_W-1:0] sample_data,
  // event pins used as trigger sources
  input wire logic first_event_pin,
  input wire logic second_event_pin,
  // register port
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic burst_end,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  // status
  output logic data_ready_flag,
  output logic watermark_flag,
  output logic overrun_flag
);
  // ****************************************
  // local constants and helpers
  // ****************************************
  localparam int AW = $clog2(DEPTH_P);
  localparam logic [5:0] DEPTH_C = 6'(DEPTH_P);
  localparam logic [1:0] SKID_FULL = 2'h2;
  localparam logic [1:0] SKID_EMPTY = 2'h0;
  localparam logic [7:0] RDATA_IDLE = 8'h00;

  function automatic logic [AW-1:0] wrap_inc(input logic [AW-1:0] p);
    return (p == AW'(DEPTH_P - 1)) ? '0 : p + AW'(1);
  endfunction

  // one decode of the axis window, so pop and read data never disagree on its edges
  function automatic logic is_axis(input logic [7:0] a);
    return a >= ADDR_X_LO && a <= ADDR_Z_HI;
  endfunction

  // ****************************************
  // control register
  // ****************************************
  logic [7:0] ctrl;
  asf_mode_t mode;
  logic [4:0] samples;
  logic zero_write;
  logic ctrl_wr;
  logic arm_write;
  assign mode = asf_mode_t'(ctrl[MODE_HI:MODE_LO]);
  assign samples = ctrl[SAMPLES_HI:0];
  assign ctrl_wr = reg_wr && reg_addr == ADDR_CTRL;
  assign zero_write = ctrl_wr && reg_wdata[SAMPLES_HI:0] == '0;
  // any write that selects trigger mode re-arms, so an old trigger never carries over
  assign arm_write = ctrl_wr && reg_wdata[MODE_HI:MODE_LO] == ASF_TRIGGER;

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      ctrl <= CTRL_RESET;
    end else if (ctrl_wr) begin
      ctrl <= reg_wdata;
    end
  end

  // ****************************************
  // two-entry skid buffer on the sample path
  // ****************************************
  logic [SAMPLE_W-1:0] skid_data [2];
  logic [1:0] skid_cnt;
  logic skid_rd_ptr;
  logic skid_wr_ptr;
  logic in_valid;
  logic in_take;
  logic [SAMPLE_W-1:0] in_data;
  // the store never refuses a word, so the skid drains each cycle; it only absorbs
  // a stall if the store side is ever given back-pressure
  assign sample_ready = skid_cnt != SKID_FULL;
  assign in_valid = skid_cnt != SKID_EMPTY;
  assign in_data = skid_data[skid_rd_ptr];

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      skid_cnt <= 2'h0;
      skid_rd_ptr <= 1'b0;
      skid_wr_ptr <= 1'b0;
    end else begin
      if (sample_valid && sample_ready) begin
        skid_wr_ptr <= ~skid_wr_ptr;
      end
      if (in_take) begin
        skid_rd_ptr <= ~skid_rd_ptr;
      end
      skid_cnt <= skid_cnt + 2'(sample_valid && sample_ready) - 2'(in_take);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sample_valid && sample_ready) begin
      skid_data[skid_wr_ptr] <= sample_data;
    end
  end

  // ****************************************
  // trigger tracking
  // ****************************************
  asf_trig_state_t trig_state;
  logic trig_src;
  logic trig_src_d;
  logic trig_edge;
  assign trig_src = ctrl[TRIG_SEL_BIT] ? second_event_pin : first_event_pin;
  assign trig_edge = trig_src && !trig_src_d;

  // detector starts low like an idle pin, so leaving reset never looks like a trigger
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      trig_src_d <= 1'b0;
    end else begin
      trig_src_d <= trig_src;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      trig_state <= ASF_ST_IDLE;
    end else if (mode != ASF_TRIGGER || ctrl_wr) begin
      trig_state <= arm_write ? ASF_ST_ARMED : ASF_ST_IDLE;
    end else begin
      case (trig_state)
        ASF_ST_IDLE: trig_state <= ASF_ST_ARMED;
        ASF_ST_ARMED: if (trig_edge) trig_state <= ASF_ST_FIRED;
        ASF_ST_FIRED: trig_state <= ASF_ST_FIRED;
        default: trig_state <= ASF_ST_IDLE;
      endcase
    end
  end

  // ****************************************
  // storage: 32 entries plus output stage
  // ****************************************
  logic [SAMPLE_W-1:0] mem [DEPTH_P];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [5:0] mem_cnt;
  logic [SAMPLE_W-1:0] out_stage;
  logic out_valid;
  logic pop;
  logic mem_full;
  logic arrive;
  logic store;
  logic drop_old;
  logic lost;
  logic to_out;
  logic [5:0] entries;
  logic [7:0] status_byte;

  assign mem_full = mem_cnt == DEPTH_C;
  assign arrive = in_valid;
  assign in_take = in_valid; // buffer never stalls the skid: drops outside the pre-trigger window are counted as overrun
  // the output stage counts as a readable level, which is how 33 entries arise
  assign entries = mem_cnt + 6'(out_valid);
  // a read of axis byte at end of burst pops one level
  assign pop = reg_rd && burst_end && is_axis(reg_addr);

  // move a word into the output stage when it empties
  assign to_out = (!out_valid || pop) && mem_cnt != 6'h0;

  always_comb begin
    store = 1'b0;
    drop_old = 1'b0;
    lost = 1'b0;
    if (arrive) begin
      case (mode)
        ASF_BYPASS: store = 1'b0;
        ASF_FILL: begin
          store = !mem_full || to_out;
          lost = !store;
        end
        ASF_STREAM: begin
          store = 1'b1;
          drop_old = mem_full && !to_out;
          lost = drop_old;
        end
        ASF_TRIGGER: begin
          if (trig_state == ASF_ST_FIRED) begin
            store = !mem_full || to_out;
            lost = !store;
          end else begin
            store = 1'b1;
            // pre-trigger window: keep only the newest samples count entries
            drop_old = !to_out && (mem_cnt >= {1'b0, samples} || mem_full);
          end
        end
        default: store = 1'b0;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      mem_cnt <= 6'h0;
    end else if (mode == ASF_BYPASS) begin
      // bypass empties the store, so a later mode starts from a clean count
      wr_ptr <= '0;
      rd_ptr <= '0;
      mem_cnt <= 6'h0;
    end else begin
      if (store) begin
        wr_ptr <= wrap_inc(wr_ptr);
      end
      if (to_out || drop_old) begin
        rd_ptr <= wrap_inc(rd_ptr);
      end
      mem_cnt <= mem_cnt + 6'(store) - 6'(to_out || drop_old);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (store) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      out_stage <= '0;
      out_valid <= 1'b0;
    end else if (mode == ASF_BYPASS) begin
      // bypass: newest sample lands directly in the axis registers
      if (arrive) begin
        out_stage <= in_data;
      end
      out_valid <= arrive ? 1'b1 : (pop ? 1'b0 : out_valid);
    end else if (to_out || drop_old && out_valid) begin
      // a drop retires the oldest readable word, which is the one in this stage;
      // refilling it keeps what the host reads a contiguous run of samples
      out_stage <= mem[rd_ptr];
      out_valid <= 1'b1;
    end else if (pop) begin
      out_valid <= 1'b0;
    end
  end

  // ****************************************
  // status flags
  // ****************************************
  logic wm_cond;
  // bypass ignores samples field; zero count latches watermark immediately
  assign wm_cond = (mode == ASF_FILL || mode == ASF_STREAM)
                   && entries >= {1'b0, samples} && samples != '0;

  // a set in the same cycle as a pop wins, so no event goes unreported
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      watermark_flag <= 1'b0;
    end else if (zero_write || wm_cond) begin
      watermark_flag <= 1'b1;
    end else if (pop) begin
      watermark_flag <= 1'b0;
    end
  end

  // overrun covers both a dropped arrival and an overwritten unread word, except pre-trigger discards
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      overrun_flag <= 1'b0;
    end else if (lost || drop_old && mode == ASF_STREAM || arrive && mode == ASF_BYPASS
                 && out_valid && !pop) begin
      overrun_flag <= 1'b1;
    end else if (pop) begin
      overrun_flag <= 1'b0;
    end
  end

  // data-ready tracks presence of a readable sample, recomputed after each pop
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      data_ready_flag <= 1'b0;
    end else begin
      data_ready_flag <= (mode == ASF_BYPASS) ? (arrive || out_valid && !pop)
                         : (entries - 6'(pop) != 6'h0 || store);
    end
  end

  // ****************************************
  // read data
  // ****************************************
  logic [7:0] source_byte;
  assign status_byte = {trig_state == ASF_ST_FIRED, 1'b0, entries};

  // bits other than the three buffer events read as zero
  always_comb begin
    source_byte = RDATA_IDLE;
    source_byte[SRC_READY_BIT] = data_ready_flag;
    source_byte[SRC_WATERMARK_BIT] = watermark_flag;
    source_byte[SRC_OVERRUN_BIT] = overrun_flag;
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      reg_rdata <= RDATA_IDLE;
    end else if (reg_rd) begin
      case (reg_addr)
        ADDR_CTRL: reg_rdata <= ctrl;
        ADDR_BUFFER_STATUS: reg_rdata <= status_byte;
        ADDR_SOURCE: reg_rdata <= source_byte;
        default: begin
          if (is_axis(reg_addr)) begin
            // twos complement words, low byte first per axis
            reg_rdata <= out_stage[8*(reg_addr - ADDR_X_LO) +: 8];
          end else begin
            reg_rdata <= RDATA_IDLE;
          end
        end
      endcase
    end
  end
endmodule

// ===== verification/asf_host_model.sv
module asf_host_model
  import asf_pkg::*;
(
  // clock
  input wire logic ref_clk,
  // register port
  output logic reg_wr,
  output logic reg_rd,
  output logic burst_end,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    burst_end = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
  end
  // tasks start and end just after a rising edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(posedge ref_clk) #1;
    reg_wr = 1'b0;
    reg_wdata = ~d;
    // idle edge, so a following call never lowers and raises a strobe in one step
    @(posedge ref_clk) #1;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    reg_rd = 1'b1;
    reg_addr = a;
    @(posedge ref_clk) #1;
    reg_rd = 1'b0;
    d = reg_rdata;
    @(posedge ref_clk) #1;
  endtask
  // one burst over all six axis bytes, so no sample tears between bytes
  task automatic burst(output logic [SAMPLE_W-1:0] s);
    for (int i = 0; i < 6; i++) begin
      reg_rd = 1'b1;
      reg_addr = ADDR_X_LO + 8'(i);
      burst_end = (i == 5);
      @(posedge ref_clk) #1;
      s[8*i +: 8] = reg_rdata;
    end
    reg_rd = 1'b0;
    burst_end = 1'b0;
    @(posedge ref_clk) #1;
  endtask
endmodule

// ===== verification/asf_sample_fifo_chk.sv
module asf_sample_fifo_chk
  import asf_pkg::*;
#(
  parameter int DEPTH_P = DEPTH
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // sampling path and event pins
  input wire logic sample_valid,
  input wire logic sample_ready,
  input wire logic [SAMPLE_W-1:0] sample_data,
  input wire logic first_event_pin,
  input wire logic second_event_pin,
  // register port and status
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic burst_end,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic data_ready_flag,
  input wire logic watermark_flag,
  input wire logic overrun_flag
);
  timeunit 1ns;
  timeprecision 1ps;
  logic pop;
  logic [3:0] vhist;
  assign pop = reg_rd && burst_end && reg_addr >= ADDR_X_LO && reg_addr <= ADDR_Z_HI;
  // a flag may rise up to four edges after the sample that caused it
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) vhist <= 4'h0;
    else vhist <= {vhist[2:0], sample_valid};
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  a_rdata_hold: assert property (!reg_rd |=> $stable(reg_rdata))
    else $error("read data changed without a read");
  a_status_shape: assert property (reg_rd && reg_addr == ADDR_BUFFER_STATUS
    |=> reg_rdata[6] == 1'b0 && reg_rdata[5:0] <= 6'(DEPTH_P + 1))
    else $error("buffer status out of shape");
  a_overrun_clear: assert property ($fell(overrun_flag) |-> $past(pop))
    else $error("overrun flag cleared without a pop");
  a_ready_clear: assert property ($fell(data_ready_flag) |-> $past(pop))
    else $error("ready flag cleared without a pop");
  a_zero_wm: assert property (reg_wr && reg_addr == ADDR_CTRL
    && reg_wdata[SAMPLES_HI:0] == 5'h00 |-> ##[1:2] watermark_flag)
    else $error("zero sample count left watermark low");
  a_overrun_cause: assert property ($rose(overrun_flag) |-> vhist != 4'h0)
    else $error("overrun raised with no sample arriving");
  a_ready_cause: assert property ($rose(data_ready_flag) |-> vhist != 4'h0)
    else $error("ready raised with no sample arriving");
  a_ready_stall: assert property (not (!sample_ready [*8]))
    else $error("sample path stalled too long");
endmodule

bind asf_sample_fifo asf_sample_fifo_chk #(.DEPTH_P(DEPTH_P)) u_asf_sample_fifo_chk (
  .ref_clk(ref_clk), .rstn(rstn),
  .sample_valid(sample_valid), .sample_ready(sample_ready), .sample_data(sample_data),
  .first_event_pin(first_event_pin), .second_event_pin(second_event_pin),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .burst_end(burst_end), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
  .data_ready_flag(data_ready_flag), .watermark_flag(watermark_flag),
  .overrun_flag(overrun_flag)
);

// ===== verification/asf_sample_fifo_test.sv
module asf_sample_fifo_test
  import asf_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk, rstn, sample_valid, sample_ready, first_event_pin, second_event_pin;
  logic reg_wr, reg_rd, burst_end, data_ready_flag, watermark_flag, overrun_flag;
  logic [SAMPLE_W-1:0] sample_data, s;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, v;
  logic [SAMPLE_W-1:0] q[$];
  int fail_count = 0;
  int n_checks = 0;
  asf_sample_fifo #(.DEPTH_P(DEPTH)) u_asf_sample_fifo (
    .ref_clk(ref_clk), .rstn(rstn),
    .sample_valid(sample_valid), .sample_ready(sample_ready), .sample_data(sample_data),
    .first_event_pin(first_event_pin), .second_event_pin(second_event_pin),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .burst_end(burst_end), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .data_ready_flag(data_ready_flag), .watermark_flag(watermark_flag),
    .overrun_flag(overrun_flag)
  );
  asf_host_model u_asf_host_model (
    .ref_clk(ref_clk), .reg_wr(reg_wr), .reg_rd(reg_rd), .burst_end(burst_end),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata)
  );
  initial ref_clk = 1'b0;
  always #4 ref_clk = ~ref_clk;
  function automatic logic [7:0] status(input logic t, input int n);
    return {t, 1'b0, 6'(n > DEPTH + 1 ? DEPTH + 1 : n)};
  endfunction
  function automatic logic [7:0] src_byte(input logic r, input logic w, input logic o);
    logic [7:0] b;
    b = 8'h00;
    b[SRC_READY_BIT] = r;
    b[SRC_WATERMARK_BIT] = w;
    b[SRC_OVERRUN_BIT] = o;
    return b;
  endfunction
  task automatic chk(input logic [SAMPLE_W-1:0] got, exp);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %0t got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic pushn(input int n);
    for (int i = 0; i < n; i++) begin
      sample_valid = 1'b1;
      sample_data = {16'($urandom), 32'($urandom)};
      q.push_back(sample_data);
      while (sample_ready !== 1'b1) @(posedge ref_clk) #1;
      @(posedge ref_clk) #1;
    end
    sample_valid = 1'b0;
    repeat (4) @(posedge ref_clk) #1;
  endtask
  task automatic drain(input int n, input int first);
    for (int i = 0; i < n; i++) begin
      u_asf_host_model.burst(s);
      chk(s, q[first + i]);
    end
    u_asf_host_model.rd(ADDR_BUFFER_STATUS, v);
    chk(48'(v), 48'(status(1'b0, 0)));
    chk(48'(data_ready_flag), 48'h0);
    q.delete();
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    #100us;
    fail_count++;
    results();
  end
  initial begin
    {rstn, sample_valid, first_event_pin, second_event_pin} = 4'h0;
    sample_data = '0;
    void'($urandom(32'hB6A65959));
    repeat (8) @(posedge ref_clk);
    #1 rstn = 1'b1;
    u_asf_host_model.rd(ADDR_BUFFER_STATUS, v);
    chk(48'(v), 48'h0);
    chk(48'({data_ready_flag, watermark_flag, overrun_flag}), 48'h0);
    u_asf_host_model.wr(ADDR_CTRL, 8'h00);
    @(posedge ref_clk) #1;
    chk(48'(watermark_flag), 48'h1);
    u_asf_host_model.wr(ADDR_CTRL, 8'h01);
    pushn(2);
    u_asf_host_model.burst(s);
    chk(s, q[1]);
    q.delete();
    $display("test bypass done");
    u_asf_host_model.wr(ADDR_CTRL, 8'h44);
    u_asf_host_model.wr(ADDR_CTRL, 8'h44);
    pushn(3);
    chk(48'(watermark_flag), 48'h0);
    pushn(1);
    chk(48'(watermark_flag), 48'h1);
    pushn(36);
    u_asf_host_model.rd(ADDR_BUFFER_STATUS, v);
    chk(48'(v), 48'(status(1'b0, 40)));
    chk(48'(overrun_flag), 48'h1);
    u_asf_host_model.rd(ADDR_SOURCE, v);
    chk(48'(v), 48'(src_byte(1'b1, 1'b1, 1'b1)));
    drain(DEPTH + 1, 0);
    $display("test fill done");
    u_asf_host_model.wr(ADDR_CTRL, 8'h9F);
    pushn(40);
    chk(48'(overrun_flag), 48'h1);
    drain(DEPTH + 1, 40 - DEPTH - 1);
    chk(48'(overrun_flag), 48'h0);
    u_asf_host_model.rd(ADDR_SOURCE, v);
    chk(48'(v), 48'(src_byte(1'b0, 1'b0, 1'b0)));
    $display("test stream done");
    for (int sel = 0; sel < 2; sel++) begin
      u_asf_host_model.wr(ADDR_CTRL, 8'hC4 | 8'(sel << TRIG_SEL_BIT));
      pushn(6);
      {first_event_pin, second_event_pin} = sel ? 2'b10 : 2'b01;
      repeat (2) @(posedge ref_clk) #1;
      {first_event_pin, second_event_pin} = 2'b00;
      u_asf_host_model.rd(ADDR_BUFFER_STATUS, v);
      chk(48'(v[TRIG_FLAG_BIT]), 48'h0);
      {first_event_pin, second_event_pin} = sel ? 2'b01 : 2'b10;
      repeat (2) @(posedge ref_clk) #1;
      {first_event_pin, second_event_pin} = 2'b00;
      repeat (3) @(posedge ref_clk) #1;
      u_asf_host_model.rd(ADDR_BUFFER_STATUS, v);
      chk(48'(v[TRIG_FLAG_BIT]), 48'h1);
    end
    $display("test trigger done");
    results();
  end
endmodule
